/* difl_pkg.sv */
// Constants shared by the drive input function logic
`default_nettype none
package difl_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_NS      = 8;
	localparam int TICK_NS     = 1_000_000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int BLOCK_DLY_MS = 20;
	localparam int SAMPLE_MS   = 100;
	localparam int TENTH_MS    = 100;
	localparam int BLINK_MS    = 250;
	// ==========================================================
	// Input function codes
	localparam logic [4:0] FN_REMOTE = 5'h05;
	localparam logic [4:0] FN_MS1    = 5'h09;
	localparam logic [4:0] FN_MS2    = 5'h0A;
	localparam logic [4:0] FN_JOG    = 5'h0B;
	localparam logic [4:0] FN_BB_NO  = 5'h0D;
	localparam logic [4:0] FN_BB_NC  = 5'h0E;
	localparam logic [4:0] FN_SS_MAX = 5'h0F;
	localparam logic [4:0] FN_SS_SET = 5'h10;
	localparam logic [4:0] FN_TIMER  = 5'h14;
	localparam logic [4:0] FN_SH     = 5'h16;
	localparam logic [4:0] FN_UD     = 5'h19;
	localparam logic [4:0] FN_PID    = 5'h1B;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_FSEL = 12'h004;
	localparam logic [11:0] A_REF0 = 12'h008;
	localparam logic [11:0] A_JOG  = 12'h020;
	localparam logic [11:0] A_LIM  = 12'h024;
	localparam logic [11:0] A_MM   = 12'h028;
	localparam logic [11:0] A_SRCH = 12'h02C;
	localparam logic [11:0] A_TMR  = 12'h030;
	localparam logic [11:0] A_ACC  = 12'h034;
	localparam logic [11:0] A_STAT = 12'h038;
	localparam logic [11:0] A_FREQ = 12'h03C;
	// ==========================================================
	// Reset values and limits
	localparam logic [15:0] JOG_RST  = 16'h003C;
	localparam logic [15:0] REF_RST  = 16'h0000;
	localparam logic [15:0] REF_MAX  = 16'h270F;
	localparam logic [31:0] LIM_RST  = 32'h0258_0000;
	localparam logic [31:0] MM_RST   = 32'h0258_0000;
	localparam logic [23:0] SRCH_RST = 24'h64_05_6E;
	localparam logic [7:0]  LVL_MAX  = 8'hC8;
	localparam logic [7:0]  VF_MAX   = 8'h64;
	localparam logic [15:0] ACC_RST  = 16'h0080;
	localparam logic [24:0] FSEL_RST = 25'h0000000;
	localparam logic [7:0]  SS_NUM   = 8'h83;
	localparam int          SS_SHIFT = 10;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_BLOCK,
		ST_MINBLK,
		ST_SEARCH
	} difl_st_e;
endpackage
`default_nettype wire

/* difl_dly_if.sv */
// Carrier between the top and a qualification timer
`timescale 1ns/100ps
`default_nettype none
interface difl_dly_if;
	logic        lvl;
	logic        qual;
	logic [15:0] on_lim;
	logic [15:0] off_lim;
	modport tmr (input lvl, input on_lim, input off_lim, output qual);
	modport usr (output lvl, output on_lim, output off_lim, input qual);
endinterface
`default_nettype wire

/* difl_delay.sv */
// On/off qualification timer counted in timebase ticks
`timescale 1ns/100ps
`default_nettype none
module difl_delay (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic tick,
	difl_dly_if.tmr   io
);
	typedef struct packed {
		logic        qual;
		logic [15:0] cnt;
	} difl_dly_s;
	difl_dly_s q;
	difl_dly_s d;
	logic [15:0] lim;
	// ==========================================================
	// Level must outlast its limit before the output follows
	always_comb
	begin
		d = q;
		lim = io.qual ? io.off_lim : io.on_lim;
		if (io.lvl == q.qual)
			d.cnt = 16'h0000;
		else if (tick)
		begin
			if (q.cnt >= lim)
			begin
				d.qual = io.lvl;
				d.cnt = 16'h0000;
			end
			else
				d.cnt = q.cnt + 16'h0001;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end
	assign io.qual = q.qual;
endmodule
`default_nettype wire

/* difl_ramp.sv */
// Output frequency ramp with fractional step
`timescale 1ns/100ps
`default_nettype none
module difl_ramp (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic        hold,
	input  wire logic [15:0] target,
	input  wire logic [15:0] step,
	output logic      [15:0] value
);
	typedef struct packed {
		logic [23:0] acc;
	} difl_ramp_s;
	difl_ramp_s q;
	difl_ramp_s d;
	logic [23:0] tgt;
	logic [23:0] stp;
	// ==========================================================
	// Eight fraction bits keep slow ramps moving
	always_comb
	begin
		d = q;
		tgt = {target, 8'h00};
		stp = {8'h00, step};
		if (load)
			d.acc = {load_val, 8'h00};
		else if (tick && !hold)
		begin
			if (q.acc + stp < tgt)
				d.acc = q.acc + stp;
			else if (q.acc > tgt + stp)
				d.acc = q.acc - stp;
			else
				d.acc = tgt;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end
	assign value = q.acc[23:8];
endmodule
`default_nettype wire

/* difl_top.sv */
// Drive multi-function contact input logic with AXI4-Lite registers
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module difl_top #(
	parameter int TICK_CYCLES = difl_pkg::TICK_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [4:0]  contact_in,
	input  wire logic        run_fwd,
	input  wire logic        run_rev,
	input  wire logic        power_loss,
	input  wire logic [15:0] analog_voltage_ref_in,
	input  wire logic [15:0] analog_current_ref_in,
	input  wire logic [7:0]  output_current_pct,
	output logic      [15:0] freq_cmd,
	output logic      [15:0] output_freq,
	output logic             output_enable,
	output logic             search_active,
	output logic      [7:0]  vf_scale,
	output logic             timer_out,
	output logic             pid_invert,
	output logic             block_indication,
	output logic             config_error
);
	typedef struct packed {
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [24:0] fsel;
		logic [6:0][15:0] refs;
		logic [31:0] lim;
		logic [31:0] mm;
		logic [23:0] srch;
		logic [15:0] tmr;
		logic [15:0] acc;
		logic [7:0]  s1;
		logic [7:0]  s2;
		logic [16:0] tcnt;
		difl_pkg::difl_st_e st;
		logic [15:0] cnt;
		logic        remote;
		logic [15:0] held;
		logic [15:0] ud;
		logic        ss_d;
		logic        from_max;
		logic        ld;
		logic [15:0] ldv;
		logic [15:0] fcmd;
		logic [8:0]  bcnt;
		logic        blink;
		logic        coast;
		logic        srch_on;
		logic [7:0]  vf;
		logic        tout;
		logic        pid;
		logic        cerr;
	} difl_top_s;
	difl_top_s q;
	difl_top_s d;

	// ==========================================================
	// Helpers
	function automatic logic fn_has(input logic [24:0] f,
		input logic [4:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++)
			if (f[i*5 +: 5] == c)
				r = 1'b1;
		return r;
	endfunction
	function automatic logic fn_on(input logic [24:0] f,
		input logic [4:0] ci, input logic [4:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++)
			if (f[i*5 +: 5] == c && ci[i])
				r = 1'b1;
		return r;
	endfunction
	function automatic logic [31:0] fn_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction
	function automatic logic [15:0] fn_max(input logic [15:0] a,
		input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction

	logic        tick;
	logic        wr;
	logic [4:0]  ci;
	logic        run;
	logic        pl;
	logic [15:0] ana;
	logic [15:0] ana_eff;
	logic [2:0]  idx;
	logic        ms_ok;
	logic        jog;
	logic        ud_mode;
	logic        up;
	logic        dn;
	logic [15:0] pre;
	logic [15:0] cmd;
	logic [15:0] lowlim;
	logic [15:0] dnlim;
	logic        blk_raw;
	logic        ss_on;
	logic [15:0] minblk;
	logic [15:0] ss_step;
	logic [31:0] wv;
	logic [3:0]  ri;
	logic [3:0]  wi;
	logic [15:0] ramp_tgt;
	logic [15:0] ramp_stp;
	difl_dly_if blk_if();
	difl_dly_if sh_if();
	difl_dly_if tm_if();

	// ==========================================================
	// Qualification timers
	assign blk_if.lvl     = blk_raw;
	assign blk_if.on_lim  = 16'(difl_pkg::BLOCK_DLY_MS);
	assign blk_if.off_lim = 16'h0000;
	assign sh_if.lvl      = fn_on(q.fsel, ci, difl_pkg::FN_SH);
	assign sh_if.on_lim   = 16'(difl_pkg::SAMPLE_MS);
	assign sh_if.off_lim  = 16'h0000;
	assign tm_if.lvl      = fn_on(q.fsel, ci, difl_pkg::FN_TIMER);
	assign tm_if.on_lim   = 16'(q.tmr[7:0] * difl_pkg::TENTH_MS);
	assign tm_if.off_lim  = 16'(q.tmr[15:8] * difl_pkg::TENTH_MS);

	difl_delay u_blk (
		.aclk   (aclk),
		.aresetn(aresetn),
		.tick   (tick),
		.io     (blk_if.tmr)
	);
	difl_delay u_sh (
		.aclk   (aclk),
		.aresetn(aresetn),
		.tick   (tick),
		.io     (sh_if.tmr)
	);
	difl_delay u_tm (
		.aclk   (aclk),
		.aresetn(aresetn),
		.tick   (tick),
		.io     (tm_if.tmr)
	);
	difl_ramp u_ramp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick),
		.load    (q.ld),
		.load_val(q.ldv),
		.hold    (q.coast),
		.target  (ramp_tgt),
		.step    (ramp_stp),
		.value   (output_freq)
	);

	// ==========================================================
	// Main logic
	always_comb
	begin
		d = q;
		// Pins pass two flops before use
		d.s1 = {power_loss, run_rev, run_fwd, contact_in};
		d.s2 = q.s1;
		ci = q.s2[4:0];
		run = q.s2[5] | q.s2[6];
		pl = q.s2[7];
		tick = (q.tcnt == 17'(TICK_CYCLES - 1));
		d.tcnt = tick ? 17'h00000 : q.tcnt + 17'h00001;
		// Bus write
		wv = 32'h00000000;
		wi = 4'(s_axi_awaddr[11:2] - difl_pkg::A_REF0[11:2]);
		if (wr)
		begin
			d.bvalid = 1'b1;
			d.bresp = 2'b00;
			case (s_axi_awaddr & 12'hFFC)
				difl_pkg::A_CTRL:
					d.ctrl = fn_merge(q.ctrl, s_axi_wdata, s_axi_wstrb);
				difl_pkg::A_FSEL:
				begin
					wv = fn_merge({7'h00, q.fsel}, s_axi_wdata,
						s_axi_wstrb);
					d.fsel = wv[24:0];
				end
				difl_pkg::A_LIM:
					d.lim = fn_merge(q.lim, s_axi_wdata, s_axi_wstrb);
				difl_pkg::A_MM:
					d.mm = fn_merge(q.mm, s_axi_wdata, s_axi_wstrb);
				difl_pkg::A_SRCH:
				begin
					wv = fn_merge({8'h00, q.srch}, s_axi_wdata,
						s_axi_wstrb);
					if (wv[7:0] > difl_pkg::LVL_MAX)
						wv[7:0] = difl_pkg::LVL_MAX;
					if (wv[23:16] > difl_pkg::VF_MAX)
						wv[23:16] = difl_pkg::VF_MAX;
					d.srch = wv[23:0];
				end
				difl_pkg::A_TMR:
				begin
					wv = fn_merge({16'h0000, q.tmr}, s_axi_wdata,
						s_axi_wstrb);
					d.tmr = wv[15:0];
				end
				difl_pkg::A_ACC:
				begin
					wv = fn_merge({16'h0000, q.acc}, s_axi_wdata,
						s_axi_wstrb);
					d.acc = wv[15:0];
				end
				default:
					if (s_axi_awaddr >= difl_pkg::A_REF0 &&
						s_axi_awaddr <= difl_pkg::A_JOG + 12'h003)
					begin
						wv = fn_merge({16'h0000, q.refs[wi[2:0]]},
							s_axi_wdata, s_axi_wstrb);
						if (wv[15:0] > difl_pkg::REF_MAX)
							wv[15:0] = difl_pkg::REF_MAX;
						d.refs[wi[2:0]] = wv[15:0];
					end
					else
						d.bresp = 2'b10;
			endcase
		end
		else if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		// Bus read
		ri = 4'(s_axi_araddr[11:2] - difl_pkg::A_REF0[11:2]);
		if (s_axi_arvalid && !q.rvalid)
		begin
			d.rvalid = 1'b1;
			d.rresp = 2'b00;
			case (s_axi_araddr & 12'hFFC)
				difl_pkg::A_CTRL: d.rdata = q.ctrl;
				difl_pkg::A_FSEL: d.rdata = {7'h00, q.fsel};
				difl_pkg::A_LIM:  d.rdata = q.lim;
				difl_pkg::A_MM:   d.rdata = q.mm;
				difl_pkg::A_SRCH: d.rdata = {8'h00, q.srch};
				difl_pkg::A_TMR:  d.rdata = {16'h0000, q.tmr};
				difl_pkg::A_ACC:  d.rdata = {16'h0000, q.acc};
				difl_pkg::A_STAT:
					d.rdata = {22'h000000, q.cerr, q.tout, q.pid,
						q.blink, q.remote, q.srch_on, q.coast,
						blk_if.qual, q.st};
				difl_pkg::A_FREQ: d.rdata = {output_freq, q.fcmd};
				default:
					if (s_axi_araddr >= difl_pkg::A_REF0 &&
						s_axi_araddr <= difl_pkg::A_JOG + 12'h003)
						d.rdata = {16'h0000, q.refs[ri[2:0]]};
					else
					begin
						d.rdata = 32'h00000000;
						d.rresp = 2'b10;
					end
			endcase
		end
		else if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		// Configuration check
		d.cerr = 1'b0;
		for (int i = 0; i < 4; i++)
			if (q.fsel[i*5 +: 5] == difl_pkg::FN_UD)
				d.cerr = 1'b1;
		if (fn_has(q.fsel, difl_pkg::FN_SS_MAX) &&
			fn_has(q.fsel, difl_pkg::FN_SS_SET))
			d.cerr = 1'b1;
		if (fn_has(q.fsel, difl_pkg::FN_SH) &&
			fn_has(q.fsel, difl_pkg::FN_UD))
			d.cerr = 1'b1;
		// Reference sources
		ana = q.ctrl[1] ? analog_current_ref_in : analog_voltage_ref_in;
		if (sh_if.qual)
			d.held = ana;
		ana_eff = fn_has(q.fsel, difl_pkg::FN_SH) ? q.held : ana;
		if (!run)
			d.remote = q.ctrl[0] &
				~fn_on(q.fsel, ci, difl_pkg::FN_REMOTE);
		ms_ok = q.fsel[14:10] == difl_pkg::FN_JOG &&
			q.fsel[19:15] == difl_pkg::FN_MS1 &&
			q.fsel[24:20] == difl_pkg::FN_MS2;
		idx = (ci[3:1] > 3'h5) ? 3'h5 : ci[3:1];
		jog = ms_ok ? ci[4] : fn_on(q.fsel, ci, difl_pkg::FN_JOG);
		pre = ms_ok ? q.refs[idx] : q.refs[0];
		if ((!ms_ok || idx == 3'h0) && q.remote)
			pre = ana_eff;
		// Up/down setting
		ud_mode = q.fsel[24:20] == difl_pkg::FN_UD && q.remote;
		up = ci[3];
		dn = ci[4];
		lowlim = fn_max(ana_eff, q.lim[15:0]);
		dnlim = fn_max(q.mm[15:0], q.lim[15:0]);
		if (!run)
			d.ud = lowlim;
		else if (tick && up && !dn && q.ud < q.lim[31:16])
			d.ud = q.ud + 16'h0001;
		else if (tick && dn && !up && q.ud > dnlim)
			d.ud = q.ud - 16'h0001;
		cmd = jog ? q.refs[6] : (ud_mode ? q.ud : pre);
		// External block, normally open or closed
		blk_raw = fn_on(q.fsel, ci, difl_pkg::FN_BB_NO) |
			(fn_has(q.fsel, difl_pkg::FN_BB_NC) &
			~fn_on(q.fsel, ~ci, difl_pkg::FN_BB_NC) == 1'b0);
		ss_on = fn_on(q.fsel, ci, difl_pkg::FN_SS_MAX) |
			fn_on(q.fsel, ci, difl_pkg::FN_SS_SET);
		d.ss_d = ss_on;
		minblk = 16'(q.srch[15:8] * difl_pkg::TENTH_MS);
		ss_step = 16'(({8'h00, q.mm[31:16]} * difl_pkg::SS_NUM)
			>> difl_pkg::SS_SHIFT);
		d.ld = 1'b0;
		// Output sequence
		case (q.st)
			difl_pkg::ST_RUN:
			begin
				if (blk_if.qual)
					d.st = difl_pkg::ST_BLOCK;
				else if (pl || (ss_on && !q.ss_d && !d.cerr))
				begin
					d.st = difl_pkg::ST_MINBLK;
					d.cnt = 16'h0000;
					d.from_max = fn_on(q.fsel, ci, difl_pkg::FN_SS_MAX);
				end
				else if (!run)
				begin
					d.ld = 1'b1;
					d.ldv = 16'h0000;
				end
			end
			difl_pkg::ST_BLOCK:
				if (!blk_if.qual)
				begin
					if (run)
					begin
						d.st = difl_pkg::ST_SEARCH;
						d.ld = 1'b1;
						d.ldv = q.fcmd;
					end
					else
						d.st = difl_pkg::ST_RUN;
				end
			difl_pkg::ST_MINBLK:
			begin
				if (tick && q.cnt < minblk)
					d.cnt = q.cnt + 16'h0001;
				if (q.cnt >= minblk && !pl)
				begin
					d.st = difl_pkg::ST_SEARCH;
					d.ld = 1'b1;
					d.ldv = q.from_max ? q.mm[31:16] : q.fcmd;
				end
			end
			difl_pkg::ST_SEARCH:
				if (blk_if.qual)
					d.st = difl_pkg::ST_BLOCK;
				else if (output_current_pct <= q.srch[7:0])
					d.st = difl_pkg::ST_RUN;
			default:
				d.st = difl_pkg::ST_RUN;
		endcase
		// Command kept while blocked, cleared without run
		if (q.st == difl_pkg::ST_BLOCK)
			d.fcmd = run ? q.fcmd : 16'h0000;
		else
			d.fcmd = cmd;
		d.coast = d.st == difl_pkg::ST_BLOCK ||
			d.st == difl_pkg::ST_MINBLK ||
			(d.st == difl_pkg::ST_RUN && !run);
		d.srch_on = d.st == difl_pkg::ST_SEARCH;
		d.vf = d.srch_on ? q.srch[23:16] : difl_pkg::VF_MAX;
		d.tout = tm_if.qual & q.ctrl[2];
		d.pid = fn_on(q.fsel, ci, difl_pkg::FN_PID);
		// Blinking block indication, quarter second phases
		if (blk_raw && tick)
		begin
			d.bcnt = q.bcnt + 9'h001;
			if (q.bcnt == 9'(difl_pkg::BLINK_MS - 1))
			begin
				d.bcnt = 9'h000;
				d.blink = ~q.blink;
			end
		end
		else if (!blk_raw)
		begin
			d.bcnt = 9'h000;
			d.blink = 1'b0;
		end
	end

	// Decelerate at the search rate while current stays high
	assign ramp_tgt = q.srch_on ? 16'h0000 : q.fcmd;
	assign ramp_stp = q.srch_on ? ss_step : q.acc;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.ctrl <= 32'h00000001;
			q.fsel <= difl_pkg::FSEL_RST;
			for (int i = 0; i < 6; i++)
				q.refs[i] <= difl_pkg::REF_RST;
			q.refs[6] <= difl_pkg::JOG_RST;
			q.lim <= difl_pkg::LIM_RST;
			q.mm <= difl_pkg::MM_RST;
			q.srch <= difl_pkg::SRCH_RST;
			q.acc <= difl_pkg::ACC_RST;
			q.st <= difl_pkg::ST_RUN;
			q.coast <= 1'b1;
			q.vf <= difl_pkg::VF_MAX;
		end
		else
			q <= d;
	end

	// ==========================================================
	// Outputs
	assign wr = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
	assign s_axi_awready = wr;
	assign s_axi_wready = wr;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = ~q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign freq_cmd = q.fcmd;
	assign output_enable = ~q.coast;
	assign search_active = q.srch_on;
	assign vf_scale = q.vf;
	assign timer_out = q.tout;
	assign pid_invert = q.pid;
	assign block_indication = q.blink;
	assign config_error = q.cerr;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_enter_min;
		q.st != difl_pkg::ST_MINBLK ##1 q.st == difl_pkg::ST_MINBLK;
	endsequence
	sequence s_blocked_idle;
		q.st == difl_pkg::ST_BLOCK && !run;
	endsequence
	chk_both_search: assert property (
		fn_has(q.fsel, difl_pkg::FN_SS_MAX) &&
		fn_has(q.fsel, difl_pkg::FN_SS_SET) |=> config_error)
		else $error("both search functions not refused");
	chk_ud_input: assert property (
		q.fsel[4:0] == difl_pkg::FN_UD |=> config_error)
		else $error("up/down on low input not flagged");
	chk_block_coast: assert property (
		q.st == difl_pkg::ST_BLOCK |-> !output_enable)
		else $error("output active while blocked");
	chk_block_clear: assert property (
		s_blocked_idle ##1 s_blocked_idle |-> freq_cmd == 16'h0000)
		else $error("command not cleared while blocked");
	chk_min_wait: assert property (
		s_enter_min |-> !output_enable [*3])
		else $error("output enabled during minimum block");
	chk_search_vf: assert property (
		search_active |-> vf_scale == q.srch[23:16])
		else $error("search V/f scale wrong");
	chk_hold_freeze: assert property (
		!sh_if.qual ##1 !sh_if.qual |-> $stable(q.held))
		else $error("held reference moved");
	chk_remote_stop: assert property (
		run && $past(run) |-> $stable(q.remote))
		else $error("remote/local changed while running");
	chk_pid_pol: assert property (
		fn_on(q.fsel, ci, difl_pkg::FN_PID) ##1 1'b1 |-> pid_invert)
		else $error("PID polarity not inverted");
endmodule
`default_nettype wire

/* difl_motor_model.sv */
// Motor and output stage stand-in giving current feedback
`timescale 1ns/100ps
`default_nettype none
module difl_motor_model (
	input  wire logic       aclk,
	input  wire logic       en,
	input  wire logic       heavy,
	output logic      [7:0] cur_pct
);
	logic heavy_q;
	// ==========================================
	// Current feedback
	// Coasting motor draws nothing; heavy load tops search level
	// Follows enable at once, so a search never sees a stale zero
	always_ff @(posedge aclk)
		heavy_q <= heavy;
	assign cur_pct = !en ? 8'h00 : (heavy_q ? 8'hA0 : 8'h3C);
endmodule
`default_nettype wire

/* difl_tb_top.sv */
// Self-checking bench for the contact input logic
`timescale 1ns/100ps
`default_nettype none
module drive_input_function_logic_tb_top;
	// ==========================================
	// Signals
	logic        aclk, aresetn, awv, awr, wv, wr_, bv, br;
	logic        arv, arr, rv, rr, run_fwd, oe, heavy, tout;
	logic        pid, blk, cerr, srch, pwr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat, rdv;
	logic [1:0]  bresp, rresp, rsp;
	logic [4:0]  ci;
	logic [15:0] av, fcmd, ofreq;
	logic [7:0]  cur, vf;
	int          error_cnt, comparisons;
	logic [11:0] ra[8] = '{12'h000, 12'h020, 12'h024, 12'h028,
		12'h02C, 12'h034, 12'h008, 12'h100};
	logic [31:0] re[8] = '{32'h1, 32'h3C, 32'h0258_0000,
		32'h0258_0000, 32'h64_05_6E, 32'h80, 32'h0, 32'h0};
	initial aclk = 1'b0;
	always #4 aclk = ~aclk;
	// ==========================================
	// Design and far side
	difl_top #(.TICK_CYCLES(10)) difl_top_i (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.contact_in(ci), .run_fwd(run_fwd), .run_rev(1'b0),
		.power_loss(pwr), .analog_voltage_ref_in(av),
		.analog_current_ref_in(16'h0000), .output_current_pct(cur),
		.freq_cmd(fcmd), .output_freq(ofreq), .output_enable(oe),
		.search_active(srch), .vf_scale(vf), .timer_out(tout),
		.pid_invert(pid), .block_indication(blk),
		.config_error(cerr));
	difl_motor_model difl_motor_model_i (.aclk(aclk), .en(oe),
		.heavy(heavy), .cur_pct(cur));
	// ==========================================
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wr_ === 1'b1)
				wv <= 1'b0;
		end
		while (bv !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arr === 1'b1)
				arv <= 1'b0;
		end
		while (rv !== 1'b1);
		rdv = rdat;
		rsp = rresp;
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// Watchdog, twice the expected 20k cycles
	initial
	begin
		#320us;
		error_cnt++;
		print_verdict();
	end
	// ==========================================
	// Main sequence
	initial
	begin
		{aresetn, awv, wv, br, arv, rr, run_fwd, heavy, pwr} = '0;
		{awa, ara, wd, ci, av} = '0;
		error_cnt = 0;
		comparisons = 0;
		cyc(8);
		aresetn <= 1'b1;
		cyc(4);
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i]);
			chk("reg", rdv, re[i]);
			chk("resp", rsp, (i == 7) ? 2'b10 : 2'b00);
		end
		wr(12'h00C, 32'hFFFF);
		rd(12'h00C);
		chk("clamp", rdv, 32'h270F);
		wr(12'h00C, 32'h0123);
		wr(12'h000, 32'h0);
		wr(12'h004, {7'h0, 15'h292B, 10'h0}); // S6 sel2, S5 sel1, S4 jog
		ci <= 5'b00010;
		cyc(20);
		chk("preset2", fcmd, 32'h0123);
		ci <= 5'b10010;
		cyc(20);
		chk("jog", fcmd, 32'h3C);
		ci <= 5'b00000;
		av <= 16'h0200;
		wr(12'h000, 32'h1);
		cyc(20);
		chk("remote", fcmd, 32'h0200);
		wr(12'h004, {22'h0, 5'h19, 5'h0});
		cyc(10);
		chk("cfgerr", cerr, 1'b1);
		wr(12'h000, 32'h0);
		wr(12'h008, 32'h50);
		wr(12'h004, 32'h0D);
		run_fwd <= 1'b1;
		cyc(300);
		ci <= 5'b00001;
		cyc(150);
		chk("blk early", oe, 1'b1);
		cyc(100);
		chk("blk coast", oe, 1'b0);
		chk("blk hold", fcmd, 32'h50);
		ci <= 5'b00000;
		cyc(8000);
		chk("recover", oe, 1'b1);
		run_fwd <= 1'b0;
		cyc(50);
		ci <= 5'b00001;
		cyc(300);
		chk("blk stop", fcmd, 32'h0);
		chk("blink low", blk, 1'b0);
		cyc(2300);
		chk("blink high", blk, 1'b1);
		ci <= 5'b00000;
		wr(12'h004, 32'h0E);
		run_fwd <= 1'b1;
		cyc(300);
		chk("nc blk", oe, 1'b0);
		ci <= 5'b00001;
		cyc(100);
		chk("nc release", oe, 1'b1);
		ci <= 5'b00000;
		wr(12'h02C, 32'h0032_016E);
		wr(12'h004, 32'h0F);
		heavy <= 1'b1;
		ci <= 5'b00001;
		cyc(500);
		chk("min block", oe, 1'b0);
		cyc(800);
		chk("searching", srch, 1'b1);
		chk("search vf", vf, 32'h32);
		chk("from max", ofreq > 16'h0200, 1'b1);
		chk("search decel", ofreq < 16'h0258, 1'b1);
		heavy <= 1'b0;
		cyc(20);
		chk("search end", srch, 1'b0);
		chk("normal vf", vf, 32'h64);
		pwr <= 1'b1;
		cyc(1500);
		chk("loss block", oe, 1'b0);
		pwr <= 1'b0;
		cyc(20);
		chk("loss resume", oe, 1'b1);
		ci <= 5'b00000;
		run_fwd <= 1'b0;
		wr(12'h000, 32'h4);
		wr(12'h030, 32'h0102);
		wr(12'h004, 32'h14);
		ci <= 5'b00001;
		cyc(1500);
		chk("ton early", tout, 1'b0);
		cyc(1000);
		chk("ton", tout, 1'b1);
		ci <= 5'b00000;
		cyc(600);
		chk("toff early", tout, 1'b1);
		cyc(800);
		chk("toff", tout, 1'b0);
		wr(12'h000, 32'h1);
		wr(12'h004, 32'h16);
		av <= 16'h0300;
		ci <= 5'b00001;
		cyc(1100);
		chk("sample", fcmd, 32'h0300);
		ci <= 5'b00000;
		cyc(20);
		av <= 16'h0100;
		cyc(20);
		chk("hold", fcmd, 32'h0300);
		wr(12'h004, 32'h1B);
		ci <= 5'b00001;
		cyc(10);
		chk("pid", pid, 1'b1);
		ci <= 5'b00000;
		cyc(10);
		chk("pid off", pid, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
